// >>> dbcs_dram_model.sv
/*
 * Far-side model: DRAM and I/O devices that answer reads with a given word
 * and pull ready low after a programmable number of busy clocks.
 * Assumes the sequencer's active-low strobes and one core clock.
 */
`default_nettype none

module dbcs_dram_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire dbcs_pkg::dbcs_strb_t strb,
  input wire logic [3:0] stall,
  input wire logic [15:0] word,
  output logic ready_n,
  output logic [15:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic busy;
  assign busy = !strb.mrd_n || !strb.we_n || !strb.iowr_n || !strb.lower_col_strobe_n;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      ready_n <= 1'b1;
      data_in <= 16'h0000;
    end else begin
      cnt <= busy ? cnt + 1 : 0;
      ready_n <= !(busy && cnt >= int'(stall));
      // a released bus must not keep the last word
      data_in <= !strb.mrd_n ? word : ~data_in;
    end
  end
endmodule : dbcs_dram_model

`default_nettype wire

// >>> dbcs_pkg.sv
/*
 * Package for the DRAM bus-cycle sequencer: register map, field layout,
 * reset values, cycle timing counts, request and strobe carriers, states.
 * Assumes a single 50 MHz core clock; all pin strobes are active low.
 */
`default_nettype none

package dbcs_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int REG_AW = 5;
  localparam int CNT_W = 4;
  localparam int CLK_MHZ = 50;

  // register offsets (byte addresses)
  localparam logic [4:0] OFS_BCT = 5'h00;
  localparam logic [4:0] OFS_DRC = 5'h04;
  localparam logic [4:0] OFS_STB = 5'h08;
  localparam logic [4:0] OFS_FLY = 5'h0C;
  localparam logic [4:0] OFS_STAT = 5'h10;

  // field positions
  localparam int CT0_LSB = 0;
  localparam int DRC_PAE_BIT = 0;
  localparam int DRC_CWS_BIT = 1;
  localparam int DRC_WTW_BIT = 2;
  localparam int SMD_LSB = 0;
  localparam int FLY_LSB = 0;
  localparam int ROW_LSB = 10;

  // reset values
  localparam logic [1:0] BCT_RST = 2'h0;
  localparam logic [2:0] DRC_RST = 3'h0;
  localparam logic [1:0] STB_RST = 2'h0;
  localparam logic [2:0] FLY_RST = 3'h0;

  // encodings
  localparam logic [1:0] CT0_REFRESH_REQUEST_OUT = 2'h1;
  localparam logic [1:0] CT0_CS0 = 2'h3;
  localparam logic [1:0] SMD_IDLE = 2'h1;
  localparam logic [1:0] SMD_STOP = 2'h2;

  // cycle timing, in core clocks; last fault-write index; fault FFFF word
  localparam logic [CNT_W-1:0] OFF_T2_MIN = 4'h3;
  localparam logic [CNT_W-1:0] OFF_RDY_CLK = 4'h3;
  localparam logic [CNT_W-1:0] ON_T2_MIN = 4'h1;
  localparam logic [CNT_W-1:0] REF_CLKS = 4'h7;
  localparam logic [CNT_W-1:0] REF_RDY_CLK = 4'h6;
  localparam logic [CNT_W-1:0] SREF_HOLD_CLK = 4'h7;
  localparam logic [CNT_W-1:0] HALT_CLKS = 4'h2;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
  localparam logic [2:0] FLT_LAST = 3'h5;
  localparam logic [DATA_W-1:0] FLT_SRC_HI = 16'hFFFF;

  typedef enum logic [1:0] {K_READ, K_WRITE, K_REFRESH} dbcs_kind_t;

  typedef struct packed {
    dbcs_kind_t kind;
    logic flyby;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dbcs_req_t;

  typedef struct packed {
    logic ras_n;
    logic lower_col_strobe_n;
    logic upper_col_strobe_n;
    logic mrd_n;
    logic we_n;
    logic iord_n;
    logic iowr_n;
  } dbcs_strb_t;

  localparam dbcs_strb_t STRB_OFF = 7'h7F;

  typedef enum logic [3:0] {
    ST_IDLE, ST_T1, ST_T2, ST_REF_PRE, ST_REF, ST_REF_POST, ST_HALT,
    ST_SREF, ST_SREF_HOLD, ST_FLT_T1, ST_FLT_T2, ST_FLT_IDLE
  } dbcs_state_t;
endpackage : dbcs_pkg

`default_nettype wire

// >>> dbcs_sequencer.sv
/*
 * DRAM bus-cycle sequencer: off/on-page DRAM reads and writes, CBR refresh,
 * self-refresh entry and cancel, fly-by DMA cycles, machine-fault writes
 * and the halt acknowledge cycle, plus its small register file.
 * Assumes the core holds req/halt/fault inputs until accepted and holds
 * pc, psw and fault_code stable while the matching cycle runs.
 * Falling-edge events are moved to the rising edge of the same state.
 */
// Behaviour
// - cycle type 01 puts refresh request on block-0 select; 11 keeps select
// - page-mode cycles only when page access enable is set
// - off-page T1: column address, RAS precharge, read strobe active
// - first T2: precharge continues, row address driven
// - second T2: RAS active, column address; third T2: both CAS active
// - column wait select adds one wait to off-page cycles
// - read ends in next T1: CAS and read strobe off, data sampled
// - ready held inactive stretches off-page cycles
// - on-page read: column in T1, RAS held, read strobe and CAS active
// - off-page write: write enable at T1, same sequence, off at end
// - write ends in next T1 with both CAS off
// - on-page write: CAS in T2, turnaround wait unless previous was write
// - CBR refresh lasts seven clocks, nine with idle before and after
// - refresh samples ready on its sixth clock, extends until active
// - idle or stop standby plus halt starts self-refresh after halt ack
// - NMI during self-refresh drops refresh request, RAS and CAS
// - hold ignored in halt ack, first seven self-refresh clocks, stop mode
// - fly-by runs I/O and memory together with fly-by waits
// - fault: six I/O writes 0..A: source low, FFFF, status word, PC
// - fault writes honour ready but not hold; fault state kept until reset
// - halt ack drives PC low 24 bits and status word low 16 bits
// - halt ack has zero waits, ignores ready and hold
// - ready adds no waits to on-page, self-refresh or halt ack
// - off-page cycles sample ready on the third T2 clock
`default_nettype none

module dbcs_sequencer (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [dbcs_pkg::REG_AW-1:0] reg_addr,
  input wire logic [dbcs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dbcs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic req_valid,
  input wire dbcs_pkg::dbcs_req_t req,
  output logic req_ready,
  output logic req_done,
  output logic [dbcs_pkg::DATA_W-1:0] rd_data,
  input wire logic halt_req,
  input wire logic fault_req,
  input wire logic [31:0] pc,
  input wire logic [31:0] processor_status_word,
  input wire logic [dbcs_pkg::DATA_W-1:0] fault_code,
  input wire logic ready_n,
  input wire logic hold_request,
  input wire logic nmi_n,
  output logic hold_ack,
  output dbcs_pkg::dbcs_strb_t strb,
  output logic cs0_refresh_request_out_n,
  output logic [dbcs_pkg::ADDR_W-1:0] addr_out,
  output logic [dbcs_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [dbcs_pkg::DATA_W-1:0] data_in
);
  function automatic logic [3:0] max4(input logic [3:0] a, input logic [3:0] b);
    max4 = (a > b) ? a : b;
  endfunction : max4

  function automatic logic [15:0] flt_word(input logic [2:0] idx,
      input logic [15:0] code, input logic [31:0] sw, input logic [31:0] p);
    case (idx)
      3'h0: flt_word = code;
      3'h1: flt_word = dbcs_pkg::FLT_SRC_HI;
      3'h2: flt_word = sw[15:0];
      3'h3: flt_word = sw[31:16];
      3'h4: flt_word = p[15:0];
      default: flt_word = p[31:16];
    endcase
  endfunction : flt_word

  // pin synchronisers: only the second stage is read
  logic [2:0] sync1_q, sync2_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
    end else begin
      sync1_q <= {ready_n, ~hold_request, nmi_n};
      sync2_q <= sync1_q;
    end
  end
  wire rdy_s = ~sync2_q[2];
  wire hold_s = ~sync2_q[1];
  wire nmi_s = ~sync2_q[0];

  // register file
  logic [1:0] ct0_q;
  logic [2:0] drc_q;
  logic [1:0] smd_q;
  logic [2:0] fly_q;
  logic [15:0] reg_rdata_q;
  dbcs_pkg::dbcs_state_t st_q, st_d;
  wire wr_bct = reg_wr && reg_addr == dbcs_pkg::OFS_BCT;
  wire wr_drc = reg_wr && reg_addr == dbcs_pkg::OFS_DRC;
  wire wr_stb = reg_wr && reg_addr == dbcs_pkg::OFS_STB;
  wire wr_fly = reg_wr && reg_addr == dbcs_pkg::OFS_FLY;
  logic ras_open_q, prev_wr_q;
  wire [15:0] stat_word = {10'h0, prev_wr_q, ras_open_q, 4'(st_q)};
  wire [15:0] rd_mux =
    (reg_addr == dbcs_pkg::OFS_BCT) ? {14'h0, ct0_q} :
    (reg_addr == dbcs_pkg::OFS_DRC) ? {13'h0, drc_q} :
    (reg_addr == dbcs_pkg::OFS_STB) ? {14'h0, smd_q} :
    (reg_addr == dbcs_pkg::OFS_FLY) ? {13'h0, fly_q} :
    (reg_addr == dbcs_pkg::OFS_STAT) ? stat_word : 16'h0000;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ct0_q <= dbcs_pkg::BCT_RST;
      drc_q <= dbcs_pkg::DRC_RST;
      smd_q <= dbcs_pkg::STB_RST;
      fly_q <= dbcs_pkg::FLY_RST;
      reg_rdata_q <= 16'h0000;
    end else begin
      if (wr_bct) ct0_q <= reg_wdata[dbcs_pkg::CT0_LSB +: 2];
      if (wr_drc) drc_q <= reg_wdata[2:0];
      if (wr_stb) smd_q <= reg_wdata[dbcs_pkg::SMD_LSB +: 2];
      if (wr_fly) fly_q <= reg_wdata[dbcs_pkg::FLY_LSB +: 3];
      reg_rdata_q <= reg_rd ? rd_mux : 16'h0000;
    end
  end
  assign reg_rdata = reg_rdata_q;

  wire dram_en = ct0_q[0];
  wire page_access_enable = drc_q[dbcs_pkg::DRC_PAE_BIT];
  wire column_wait_select = drc_q[dbcs_pkg::DRC_CWS_BIT];
  wire wtw = drc_q[dbcs_pkg::DRC_WTW_BIT];
  wire sb_mode = smd_q == dbcs_pkg::SMD_IDLE || smd_q == dbcs_pkg::SMD_STOP;

  // sequencer state
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] fidx_q, fidx_d;
  dbcs_pkg::dbcs_req_t cur_q, cur_d;
  logic onp_q, onp_d, rdy_seen_q, rdy_seen_d, done_d, hack_d;
  logic ras_open_d, prev_wr_d;
  logic [13:0] row_q, row_d;
  dbcs_pkg::dbcs_strb_t strb_q, strb_d;
  logic [23:0] addr_q, addr_d;
  logic [15:0] dout_q, dout_d, rdat_q, rdat_d;
  logic doe_q, doe_d, hack_q, done_q, cs0_q, rdy_q;

  wire [3:0] cnt_inc = (cnt_q == dbcs_pkg::CNT_MAX) ? cnt_q : cnt_q + 4'h1;
  wire req_rd = cur_q.kind == dbcs_pkg::K_READ;
  wire req_wr = cur_q.kind == dbcs_pkg::K_WRITE;
  wire [13:0] req_row = req.addr[23:dbcs_pkg::ROW_LSB];
  wire page_hit = page_access_enable && ras_open_q && req_row == row_q;
  wire [23:0] row_addr = {10'h000, cur_q.addr[23:dbcs_pkg::ROW_LSB]};
  wire [3:0] off_min = dbcs_pkg::OFF_T2_MIN + {3'h0, column_wait_select};
  wire [3:0] on_min = dbcs_pkg::ON_T2_MIN + {3'h0, req_wr && wtw && !prev_wr_q};
  wire [3:0] t2_min = max4(onp_q ? on_min : off_min,
                           cur_q.flyby ? {1'b0, fly_q} : 4'h0);
  // ready counts only off-page, refresh and fault writes
  wire rdy_win = rdy_s && ((st_q == dbcs_pkg::ST_T2 && !onp_q &&
                 cnt_q >= dbcs_pkg::OFF_RDY_CLK) ||
                 (st_q == dbcs_pkg::ST_REF && cnt_q >= dbcs_pkg::REF_RDY_CLK) ||
                 st_q == dbcs_pkg::ST_FLT_T2);
  wire t2_end = cnt_q >= t2_min && (onp_q || rdy_seen_d);
  wire sref_hold_ok = smd_q == dbcs_pkg::SMD_IDLE &&
                      cnt_q >= dbcs_pkg::SREF_HOLD_CLK;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_inc;
    fidx_d = fidx_q;
    cur_d = cur_q;
    onp_d = onp_q;
    rdy_seen_d = rdy_seen_q | rdy_win;
    done_d = 1'b0;
    hack_d = 1'b0;
    ras_open_d = ras_open_q;
    prev_wr_d = prev_wr_q;
    row_d = row_q;
    strb_d = strb_q;
    addr_d = addr_q;
    dout_d = dout_q;
    rdat_d = rdat_q;
    doe_d = doe_q;
    case (st_q)
      dbcs_pkg::ST_IDLE: begin
        cnt_d = 4'h1;
        rdy_seen_d = 1'b0;
        doe_d = 1'b0;
        if (fault_req) begin
          st_d = dbcs_pkg::ST_FLT_T1;
          fidx_d = 3'h0;
          addr_d = 24'h000000;
          dout_d = flt_word(3'h0, fault_code, processor_status_word, pc);
          doe_d = 1'b1;
          strb_d = dbcs_pkg::STRB_OFF;
          ras_open_d = 1'b0;
        end else if (halt_req) begin
          st_d = dbcs_pkg::ST_HALT;
          addr_d = pc[23:0];
          dout_d = processor_status_word[15:0];
          doe_d = 1'b1;
        end else if (hold_s) begin
          hack_d = 1'b1;
          strb_d = dbcs_pkg::STRB_OFF;
          ras_open_d = 1'b0;
        end else if (req_valid && rdy_q) begin
          cur_d = req;
          onp_d = page_hit && req.kind != dbcs_pkg::K_REFRESH;
          addr_d = req.addr;
          dout_d = req.wdata;
          strb_d = dbcs_pkg::STRB_OFF;
          if (req.kind == dbcs_pkg::K_REFRESH) begin
            st_d = dbcs_pkg::ST_REF_PRE;
            ras_open_d = 1'b0;
          end else begin
            st_d = dbcs_pkg::ST_T1;
            doe_d = req.kind == dbcs_pkg::K_WRITE && !req.flyby;
            strb_d.ras_n = !page_hit;
            strb_d.mrd_n = req.kind != dbcs_pkg::K_READ;
            strb_d.we_n = req.kind != dbcs_pkg::K_WRITE;
            strb_d.lower_col_strobe_n = !(page_hit && req.kind == dbcs_pkg::K_READ);
            strb_d.upper_col_strobe_n = strb_d.lower_col_strobe_n;
            // fly-by moves data between memory and I/O in one cycle
            strb_d.iowr_n = !(req.flyby && req.kind == dbcs_pkg::K_READ);
            strb_d.iord_n = !(req.flyby && req.kind == dbcs_pkg::K_WRITE);
          end
        end
      end
      dbcs_pkg::ST_T1: begin
        st_d = dbcs_pkg::ST_T2;
        cnt_d = 4'h1;
        if (!onp_q) begin
          addr_d = row_addr;
        end else if (req_wr) begin
          strb_d.lower_col_strobe_n = 1'b0;
          strb_d.upper_col_strobe_n = 1'b0;
        end
      end
      dbcs_pkg::ST_T2: begin
        if (!onp_q && cnt_q == 4'h1) begin
          strb_d.ras_n = 1'b0;
          addr_d = cur_q.addr;
        end
        if (!onp_q && cnt_q == 4'h2) begin
          strb_d.lower_col_strobe_n = 1'b0;
          strb_d.upper_col_strobe_n = 1'b0;
        end
        if (t2_end) begin
          st_d = dbcs_pkg::ST_IDLE;
          strb_d = dbcs_pkg::STRB_OFF;
          strb_d.ras_n = !page_access_enable;
          ras_open_d = page_access_enable;
          row_d = cur_q.addr[23:dbcs_pkg::ROW_LSB];
          prev_wr_d = req_wr;
          rdat_d = req_rd ? data_in : rdat_q;
          doe_d = 1'b0;
          done_d = 1'b1;
        end
      end
      dbcs_pkg::ST_REF_PRE: begin
        st_d = dbcs_pkg::ST_REF;
        cnt_d = 4'h1;
        rdy_seen_d = 1'b0;
        strb_d.lower_col_strobe_n = 1'b0;
        strb_d.upper_col_strobe_n = 1'b0;
      end
      dbcs_pkg::ST_REF: begin
        if (cnt_q == 4'h1) strb_d.ras_n = 1'b0;
        if (cnt_q >= dbcs_pkg::REF_CLKS && rdy_seen_d) begin
          st_d = dbcs_pkg::ST_REF_POST;
          strb_d = dbcs_pkg::STRB_OFF;
        end
      end
      dbcs_pkg::ST_REF_POST: begin
        st_d = dbcs_pkg::ST_IDLE;
        done_d = 1'b1;
      end
      dbcs_pkg::ST_HALT: begin
        if (cnt_q >= dbcs_pkg::HALT_CLKS) begin
          doe_d = 1'b0;
          done_d = 1'b1;
          strb_d = dbcs_pkg::STRB_OFF;
          ras_open_d = 1'b0;
          st_d = sb_mode ? dbcs_pkg::ST_SREF : dbcs_pkg::ST_IDLE;
          cnt_d = 4'h0;
        end
      end
      dbcs_pkg::ST_SREF: begin
        if (cnt_q == 4'h0) begin
          strb_d.lower_col_strobe_n = 1'b0;
          strb_d.upper_col_strobe_n = 1'b0;
        end
        if (cnt_q == 4'h1) strb_d.ras_n = 1'b0;
        if (nmi_s) begin
          st_d = dbcs_pkg::ST_IDLE;
          strb_d = dbcs_pkg::STRB_OFF;
        end else if (hold_s && sref_hold_ok) begin
          st_d = dbcs_pkg::ST_SREF_HOLD;
          hack_d = 1'b1;
          strb_d = dbcs_pkg::STRB_OFF;
        end
      end
      dbcs_pkg::ST_SREF_HOLD: begin
        hack_d = hold_s;
        cnt_d = 4'h0;
        if (!hold_s) st_d = dbcs_pkg::ST_SREF;
      end
      dbcs_pkg::ST_FLT_T1: begin
        st_d = dbcs_pkg::ST_FLT_T2;
        cnt_d = 4'h1;
        rdy_seen_d = 1'b0;
        // strobe drops between writes so each one is a cycle of its own
        strb_d.iowr_n = 1'b0;
      end
      dbcs_pkg::ST_FLT_T2: begin
        if (rdy_seen_d) begin
          strb_d.iowr_n = 1'b1;
          fidx_d = fidx_q + 3'h1;
          if (fidx_q == dbcs_pkg::FLT_LAST) begin
            st_d = dbcs_pkg::ST_FLT_IDLE;
            doe_d = 1'b0;
          end else begin
            st_d = dbcs_pkg::ST_FLT_T1;
            addr_d = {20'h00000, fidx_d, 1'b0};
            dout_d = flt_word(fidx_d, fault_code, processor_status_word, pc);
          end
        end
      end
      dbcs_pkg::ST_FLT_IDLE: begin
        hack_d = hold_s;
        strb_d = dbcs_pkg::STRB_OFF;
      end
      default: st_d = dbcs_pkg::ST_IDLE;
    endcase
  end

  // block-0 select pin: refresh request in mode 01, chip select in mode 11
  wire refresh_request_out_act = st_d == dbcs_pkg::ST_REF_PRE || st_d == dbcs_pkg::ST_REF ||
                   st_d == dbcs_pkg::ST_SREF;
  wire cs0_act = st_d == dbcs_pkg::ST_T1 || st_d == dbcs_pkg::ST_T2 ||
                 refresh_request_out_act || st_d == dbcs_pkg::ST_FLT_T1 ||
                 st_d == dbcs_pkg::ST_FLT_T2;
  wire cs0_d = (ct0_q == dbcs_pkg::CT0_REFRESH_REQUEST_OUT) ? !refresh_request_out_act :
               (ct0_q == dbcs_pkg::CT0_CS0) ? !cs0_act : 1'b1;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= dbcs_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      fidx_q <= 3'h0;
      cur_q <= '0;
      onp_q <= 1'b0;
      rdy_seen_q <= 1'b0;
      ras_open_q <= 1'b0;
      prev_wr_q <= 1'b0;
      row_q <= 14'h0000;
      strb_q <= dbcs_pkg::STRB_OFF;
      addr_q <= 24'h000000;
      dout_q <= 16'h0000;
      rdat_q <= 16'h0000;
      doe_q <= 1'b0;
      hack_q <= 1'b0;
      done_q <= 1'b0;
      cs0_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      fidx_q <= fidx_d;
      cur_q <= cur_d;
      onp_q <= onp_d;
      rdy_seen_q <= rdy_seen_d;
      ras_open_q <= ras_open_d;
      prev_wr_q <= prev_wr_d;
      row_q <= row_d;
      strb_q <= strb_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      rdat_q <= rdat_d;
      doe_q <= doe_d;
      hack_q <= hack_d;
      done_q <= done_d;
      cs0_q <= cs0_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) rdy_q <= 1'b0;
    else rdy_q <= st_d == dbcs_pkg::ST_IDLE && !fault_req && !halt_req &&
                  !hold_s && dram_en;
  end

  assign req_ready = rdy_q;
  assign req_done = done_q;
  assign rd_data = rdat_q;
  assign hold_ack = hack_q;
  assign strb = strb_q;
  assign cs0_refresh_request_out_n = cs0_q;
  assign addr_out = addr_q;
  assign data_out = dout_q;
  assign data_oe = doe_q;

  property p_offpage_t1;
    @(posedge core_clk) disable iff (!rstn)
    st_q == dbcs_pkg::ST_T1 && !onp_q && req_rd |-> strb.ras_n && !strb.mrd_n;
  endproperty
  a_offpage_t1: assert property (p_offpage_t1) else $error("off-page T1 bad");

  property p_cas_third;
    @(posedge core_clk) disable iff (!rstn)
    st_q == dbcs_pkg::ST_T2 && !onp_q && cnt_q == 4'h3 |->
      !strb.ras_n && !strb.lower_col_strobe_n && !strb.upper_col_strobe_n;
  endproperty
  a_cas_third: assert property (p_cas_third) else $error("CAS late");

  property p_ref_len;
    @(posedge core_clk) disable iff (!rstn)
    $rose(st_q == dbcs_pkg::ST_REF) |-> (st_q == dbcs_pkg::ST_REF)[*7];
  endproperty
  a_ref_len: assert property (p_ref_len) else $error("refresh short");

  property p_ref_wait;
    @(posedge core_clk) disable iff (!rstn)
    st_q == dbcs_pkg::ST_REF && !rdy_seen_q && !rdy_s |=> st_q == dbcs_pkg::ST_REF;
  endproperty
  a_ref_wait: assert property (p_ref_wait) else $error("refresh no wait");

  property p_nmi_cancel;
    @(posedge core_clk) disable iff (!rstn)
    st_q == dbcs_pkg::ST_SREF && nmi_s |=> strb.ras_n && strb.lower_col_strobe_n &&
      strb.upper_col_strobe_n && st_q == dbcs_pkg::ST_IDLE;
  endproperty
  a_nmi_cancel: assert property (p_nmi_cancel) else $error("NMI ignored");

  property p_flt_addr;
    @(posedge core_clk) disable iff (!rstn)
    st_q == dbcs_pkg::ST_FLT_T1 |-> addr_out == {20'h00000, fidx_q, 1'b0};
  endproperty
  a_flt_addr: assert property (p_flt_addr) else $error("fault addr");

  property p_flt_stay;
    @(posedge core_clk) disable iff (!rstn)
    st_q == dbcs_pkg::ST_FLT_IDLE |=> st_q == dbcs_pkg::ST_FLT_IDLE;
  endproperty
  a_flt_stay: assert property (p_flt_stay) else $error("fault left");

  property p_halt_len;
    @(posedge core_clk) disable iff (!rstn)
    $rose(st_q == dbcs_pkg::ST_HALT) |-> ##1 st_q == dbcs_pkg::ST_HALT
      ##1 st_q != dbcs_pkg::ST_HALT;
  endproperty
  a_halt_len: assert property (p_halt_len) else $error("halt ack waits");

  property p_no_hold;
    @(posedge core_clk) disable iff (!rstn)
    st_q == dbcs_pkg::ST_HALT || (st_q == dbcs_pkg::ST_SREF &&
      cnt_q < dbcs_pkg::SREF_HOLD_CLK) |=> !hold_ack;
  endproperty
  a_no_hold: assert property (p_no_hold) else $error("hold taken");

  c_read: cover property (@(posedge core_clk) disable iff (!rstn)
    st_q == dbcs_pkg::ST_T2 && !onp_q && req_rd ##1 req_done);
  c_ref: cover property (@(posedge core_clk) disable iff (!rstn)
    st_q == dbcs_pkg::ST_REF_POST);
  c_nmi: cover property (@(posedge core_clk) disable iff (!rstn)
    st_q == dbcs_pkg::ST_SREF && nmi_s);
  c_flt: cover property (@(posedge core_clk) disable iff (!rstn)
    st_q == dbcs_pkg::ST_FLT_IDLE);
endmodule : dbcs_sequencer

`default_nettype wire

// >>> dbcs_tb.sv
/*
 * Self-checking bench for the DRAM bus-cycle sequencer with random cycles.
 * Assumes the far-side model in dbcs_dram_model and a 50 MHz core clock.
 */
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, reg_wr, reg_rd, req_valid, halt_req, fault_req;
  logic hold_request, nmi_n, req_ready, req_done, hold_ack, cs0_refresh_request_out_n;
  logic data_oe, ready_n, cs_low, wd_ok, hp_ok, hack;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_data, fault_code, data_out, data_in;
  logic [15:0] word;
  logic [3:0] stall;
  logic [31:0] pc, processor_status_word;
  logic [23:0] addr_out;
  dbcs_pkg::dbcs_req_t req;
  dbcs_pkg::dbcs_strb_t strb;
  int fail_count, checked, dur;

  dbcs_sequencer i_dbcs_sequencer (.core_clk, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .req_valid, .req, .req_ready, .req_done,
    .rd_data, .halt_req, .fault_req, .pc, .processor_status_word, .fault_code, .ready_n,
    .hold_request, .nmi_n, .hold_ack, .strb, .cs0_refresh_request_out_n, .addr_out,
    .data_out, .data_oe, .data_in);
  dbcs_dram_model i_dbcs_dram_model (.core_clk, .rstn, .strb, .stall, .word,
    .ready_n, .data_in);

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, exp);
  endtask : rd

  task automatic rst;
    rstn <= 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
  endtask : rst

  // records what the pins showed until req_done or n clocks
  task automatic watch(input int n);
    cs_low = 1'b0;
    wd_ok = 1'b0;
    hp_ok = 1'b0;
    hack = 1'b0;
    for (dur = 1; dur <= n; dur++) begin
      @(posedge core_clk);
      #1;
      cs_low |= !cs0_refresh_request_out_n;
      wd_ok |= !strb.we_n && data_oe && data_out === req.wdata;
      hp_ok |= addr_out === pc[23:0] && data_out === processor_status_word[15:0];
      hack |= hold_ack;
      if (req_done) break;
    end
  endtask : watch

  task automatic run(input dbcs_pkg::dbcs_req_t r);
    @(posedge core_clk);
    req <= r;
    req_valid <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (req_ready) break;
    end
    req_valid <= 1'b0;
    watch(80);
  endtask : run

  function automatic int exp_min(input logic c, input int s, input int k);
    int m;
    m = (k == 2) ? 8 : 4 + int'(c);
    return (s + 4 > m) ? s + 4 : m;
  endfunction : exp_min

  function automatic logic [15:0] flt(input int k);
    case (k)
      0: return fault_code;
      1: return 16'hFFFF;
      2: return processor_status_word[15:0];
      3: return processor_status_word[31:16];
      4: return pc[15:0];
      default: return pc[31:16];
    endcase
  endfunction : flt

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    dbcs_pkg::dbcs_req_t r;
    logic column_wait_select;
    int k, i, da;
    {rstn, reg_wr, reg_rd, req_valid, halt_req, fault_req} = 6'h00;
    {hold_request, nmi_n, reg_addr, reg_wdata, req} = '0;
    nmi_n = 1'b1;
    {pc, processor_status_word, fault_code, stall, word} = '0;
    void'($urandom(11554));
    rst();
    rd(dbcs_pkg::OFS_BCT, 16'h0000);
    rd(5'h14, 16'h0000);
    for (int n = 0; n < 16; n++) begin
      column_wait_select = 1'($urandom_range(1));
      k = $urandom_range(2);
      r = '{dbcs_pkg::dbcs_kind_t'(k), n > 11 && k < 2, 24'($urandom),
        16'($urandom)};
      wr(dbcs_pkg::OFS_DRC, {14'h0000, column_wait_select, 1'b0});
      wr(dbcs_pkg::OFS_BCT, n[0] ? 16'h0003 : 16'h0001);
      rd(dbcs_pkg::OFS_BCT, n[0] ? 16'h0003 : 16'h0001);
      stall <= 4'($urandom_range(7));
      word <= 16'($urandom);
      run(r);
      cmp(dur >= exp_min(column_wait_select, int'(stall), k) && dur < 80, 1);
      cmp({strb.lower_col_strobe_n, strb.upper_col_strobe_n, strb.mrd_n}, 3'h7);
      if (k == 2 && !n[0]) cmp(cs_low, 1);
      if (k < 2 && !r.flyby) cmp(cs_low, n[0]);
      if (k == 0 && !r.flyby) cmp(rd_data, word);
      if (k == 1 && !r.flyby) cmp(wd_ok, 1);
    end
    wr(dbcs_pkg::OFS_DRC, 16'h0001);
    stall <= 4'h0;
    r.kind = dbcs_pkg::K_READ;
    r.flyby = 1'b0;
    run(r);
    stall <= 4'hF;
    word <= 16'h5AC3;
    run(r);
    cmp(dur < 5, 1);
    cmp(rd_data, 16'h5AC3);
    wr(dbcs_pkg::OFS_DRC, 16'h0005);
    r.kind = dbcs_pkg::K_WRITE;
    run(r);
    da = dur;
    run(r);
    cmp(da, dur + 1);
    wr(dbcs_pkg::OFS_BCT, 16'h0001);
    wr(dbcs_pkg::OFS_STB, {14'h0000, dbcs_pkg::SMD_IDLE});
    @(posedge core_clk);
    pc <= $urandom;
    processor_status_word <= $urandom;
    hold_request <= 1'b1;
    halt_req <= 1'b1;
    watch(12);
    cmp(hp_ok, 1);
    cmp(hack, 0);
    cmp(dur < 6, 1);
    for (i = 1; i <= 30 && !hold_ack; i++) begin
      @(posedge core_clk);
      #1;
      if (i == 5) cmp({strb.ras_n, strb.lower_col_strobe_n, cs0_refresh_request_out_n}, 3'h0);
    end
    cmp(i >= 6 && hold_ack, 1);
    @(posedge core_clk);
    hold_request <= 1'b0;
    repeat (8) @(posedge core_clk);
    nmi_n <= 1'b0;
    // the halt was taken long ago; a standing request would restart it
    halt_req <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    cmp({strb.ras_n, strb.lower_col_strobe_n, strb.upper_col_strobe_n, cs0_refresh_request_out_n}, 4'hF);
    halt_req <= 1'b0;
    nmi_n <= 1'b1;
    rst();
    wr(dbcs_pkg::OFS_BCT, 16'h0001);
    @(posedge core_clk);
    fault_code <= 16'($urandom);
    stall <= 4'($urandom_range(5));
    fault_req <= 1'b1;
    for (int f = 0; f < 6; f++) begin
      for (i = 0; i < 60 && strb.iowr_n !== 1'b0; i++) begin
        @(posedge core_clk);
        #1;
      end
      cmp(addr_out, 24'(2 * f));
      cmp(data_out, flt(f));
      for (i = 0; i < 60 && strb.iowr_n === 1'b0; i++) begin
        @(posedge core_clk);
        #1;
      end
    end
    hold_request <= 1'b1;
    req_valid <= 1'b1;
    watch(12);
    cmp({hack, req_ready, req_done}, 3'h4);
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
